// *** shared/oame_pkg.sv ***
// Constants and carrier types for the OR, copy and load-immediate executor.
// Assumes a 12-bit opcode word and an 8-bit datapath with 32 file registers.
package oame_pkg;
   localparam int          OPC_W        = 12;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 5;
   localparam int          NUM_REGS     = 32;
   localparam int          DEST_BIT     = 5;
   localparam logic [3:0]  OP_ORI       = 4'hd;
   localparam logic [3:0]  OP_LDI       = 4'hc;
   localparam logic [5:0]  OP_ORREG     = 6'h04;
   localparam logic [5:0]  OP_COPY      = 6'h08;
   localparam logic [7:0]  ACC_RESET    = 8'h00;
   localparam logic [7:0]  ZERO_BYTE    = 8'h00;

   typedef enum logic [2:0]
   {
      OAME_NONE,
      OAME_OR_IMMEDIATE_INTO_ACCUMULATOR,
      OAME_OR_ACCUMULATOR_WITH_REGISTER,
      OAME_COPY_REGISTER,
      OAME_LOAD_IMMEDIATE
   } oame_op_type;

   // Write request toward the file register array.
   typedef struct packed
   {
      logic              en;
      logic [4:0]        addr;
      logic [7:0]        data;
   } oame_wr_type;
endpackage

// *** hdl/oame_exec.sv ***
// Executes four single-cycle instructions of an 8-bit core: two ORs, a register
// copy and a literal load. Assumes the register file is outside, read
// combinationally at the addressed index and written on the next clock edge.
// Overview of operation
// - Opcode 1101 kkkk kkkk: accumulator ORed with literal, zero flag updated, one cycle.
// - Opcode 0001 00df ffff: accumulator ORed with file register, zero flag, one cycle.
// - Register OR result goes to accumulator when d is 0, register when 1.
// - Opcode 0010 00df ffff copies register to accumulator or itself, updating zero.
// - Copy with d of 1 keeps register value yet sets zero flag from it.
`timescale 1ns/10ps
module oame_exec
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rstn_i,
   // Instruction issue, one per cycle while valid
   input  wire logic                 instr_valid_i,
   input  wire logic [11:0]          instr_i,
   // File register read port
   output logic      [4:0]           rd_addr_o,
   input  wire logic [7:0]           rd_data_i,
   // File register write port and executor state
   output oame_pkg::oame_wr_type     wr_o,
   output logic      [7:0]           acc_o,
   output logic                      zero_o,
   output logic                      handled_o
);

////////////////////////////////////////////////////////////////////////////////

   oame_pkg::oame_op_type op;
   logic                  dest_reg;
   logic [7:0]            literal;
   logic [7:0]            result;
   logic                  acc_we;
   logic                  zero_we;
   logic [7:0]            next_acc;
   logic                  next_zero;
   oame_pkg::oame_wr_type next_wr;

   function automatic oame_pkg::oame_op_type decode(input logic [11:0] w);
      if (w[11:8] == oame_pkg::OP_ORI)
         return oame_pkg::OAME_OR_IMMEDIATE_INTO_ACCUMULATOR;
      if (w[11:8] == oame_pkg::OP_LDI)
         return oame_pkg::OAME_LOAD_IMMEDIATE;
      if (w[11:6] == oame_pkg::OP_ORREG)
         return oame_pkg::OAME_OR_ACCUMULATOR_WITH_REGISTER;
      if (w[11:6] == oame_pkg::OP_COPY)
         return oame_pkg::OAME_COPY_REGISTER;
      return oame_pkg::OAME_NONE;
   endfunction

   assign op        = instr_valid_i ? decode(instr_i) : oame_pkg::OAME_NONE;
   assign dest_reg  = instr_i[oame_pkg::DEST_BIT];
   assign literal   = instr_i[7:0];
   assign rd_addr_o = instr_i[4:0];
   assign handled_o = (op != oame_pkg::OAME_NONE);

////////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      result  = oame_pkg::ZERO_BYTE;
      acc_we  = 1'b0;
      zero_we = 1'b0;
      next_wr = '0;
      unique case (op)
         oame_pkg::OAME_OR_IMMEDIATE_INTO_ACCUMULATOR:
         begin
            result  = acc_o | literal;
            acc_we  = 1'b1;
            zero_we = 1'b1;
         end
         oame_pkg::OAME_OR_ACCUMULATOR_WITH_REGISTER:
         begin
            result  = acc_o | rd_data_i;
            zero_we = 1'b1;
            acc_we  = !dest_reg;
            next_wr = '{en: dest_reg, addr: instr_i[4:0], data: result};
         end
         oame_pkg::OAME_COPY_REGISTER:
         begin
            // Writing the same value back keeps the register; with d set only zero moves.
            result  = rd_data_i;
            zero_we = 1'b1;
            acc_we  = !dest_reg;
            next_wr = '{en: dest_reg, addr: instr_i[4:0], data: result};
         end
         oame_pkg::OAME_LOAD_IMMEDIATE:
         begin
            result = literal;
            acc_we = 1'b1;
         end
         oame_pkg::OAME_NONE:
         begin
            result = oame_pkg::ZERO_BYTE;
         end
      endcase
   end

   assign next_acc  = acc_we ? result : acc_o;
   assign next_zero = zero_we ? (result == oame_pkg::ZERO_BYTE) : zero_o;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         acc_o  <= oame_pkg::ACC_RESET;
         zero_o <= 1'b0;
         wr_o   <= '0;
      end
      else
      begin
         acc_o  <= next_acc;
         zero_o <= next_zero;
         wr_o   <= next_wr;
      end
   end

////////////////////////////////////////////////////////////////////////////////

   // Each instruction kind is named once here, so the properties read as issue, then effect.
   sequence s_ori_issue;
      instr_valid_i && instr_i[11:8] == oame_pkg::OP_ORI;
   endsequence

   sequence s_ldi_issue;
      instr_valid_i && instr_i[11:8] == oame_pkg::OP_LDI;
   endsequence

   sequence s_orreg_issue;
      instr_valid_i && instr_i[11:6] == oame_pkg::OP_ORREG;
   endsequence

   sequence s_orreg_to_acc;
      instr_valid_i && instr_i[11:6] == oame_pkg::OP_ORREG && !instr_i[oame_pkg::DEST_BIT];
   endsequence

   sequence s_orreg_to_reg;
      instr_valid_i && instr_i[11:6] == oame_pkg::OP_ORREG && instr_i[oame_pkg::DEST_BIT];
   endsequence

   sequence s_copy_to_acc;
      instr_valid_i && instr_i[11:6] == oame_pkg::OP_COPY && !instr_i[oame_pkg::DEST_BIT];
   endsequence

   sequence s_copy_to_reg;
      instr_valid_i && instr_i[11:6] == oame_pkg::OP_COPY && instr_i[oame_pkg::DEST_BIT];
   endsequence

   sequence s_no_issue;
      !handled_o;
   endsequence

   // Recomputed from the pins rather than taken from op, so a slip in the decoder shows up here.
   logic known_issue;
   logic to_reg_issue;

   assign known_issue  = instr_valid_i && (instr_i[11:8] == oame_pkg::OP_ORI || instr_i[11:8] == oame_pkg::OP_LDI
                         || instr_i[11:6] == oame_pkg::OP_ORREG || instr_i[11:6] == oame_pkg::OP_COPY);
   assign to_reg_issue = instr_valid_i && instr_i[oame_pkg::DEST_BIT]
                         && (instr_i[11:6] == oame_pkg::OP_ORREG || instr_i[11:6] == oame_pkg::OP_COPY);

   a_ori_acc_value: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_ori_issue |=> acc_o == ($past(acc_o) | $past(instr_i[7:0])) && zero_o == (acc_o == oame_pkg::ZERO_BYTE))
      else $error("or immediate gave wrong accumulator or zero");

   a_ori_no_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_ori_issue |=> !wr_o.en)
      else $error("or immediate issued a register write");

   a_orreg_zero_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_orreg_issue
      |=> zero_o == (($past(acc_o) | $past(rd_data_i)) == oame_pkg::ZERO_BYTE))
      else $error("register or zero flag wrong");

   a_orreg_to_acc: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_orreg_to_acc
      |=> acc_o == ($past(acc_o) | $past(rd_data_i)) && !wr_o.en)
      else $error("register or to accumulator wrong");

   // With d set the accumulator must not move; the OR lands only on the write port.
   a_orreg_to_reg: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_orreg_to_reg
      |=> wr_o.en && wr_o.addr == $past(instr_i[4:0]) && acc_o == $past(acc_o)
          && wr_o.data == ($past(acc_o) | $past(rd_data_i)))
      else $error("register or write back wrong");

   a_copy_to_acc: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_copy_to_acc
      |=> acc_o == $past(rd_data_i) && zero_o == ($past(rd_data_i) == oame_pkg::ZERO_BYTE) && !wr_o.en)
      else $error("copy to accumulator wrong");

   // The write-back carries the value just read, so the register ends where it began.
   a_copy_test_reg: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_copy_to_reg |=> wr_o.en && wr_o.addr == $past(instr_i[4:0]) && wr_o.data == $past(rd_data_i)
          && $stable(acc_o) && zero_o == ($past(rd_data_i) == oame_pkg::ZERO_BYTE))
      else $error("register test changed state wrongly");

   a_ldi_no_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_ldi_issue
      |=> acc_o == $past(instr_i[7:0]) && $stable(zero_o) && !wr_o.en)
      else $error("load immediate wrong");

   // Refused words and idle cycles must leave every piece of state alone.
   a_idle_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_no_issue |=> $stable(acc_o) && $stable(zero_o) && !wr_o.en)
      else $error("state changed without instruction");

   // A write pulse may only follow an instruction that targets the file register.
   a_wr_only_to_reg: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !to_reg_issue |=> !wr_o.en)
      else $error("register write without a register destination");

   // Bits 11 to 6 must match in full; near misses such as 0001 01xx are refused.
   a_handled_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
      handled_o == known_issue)
      else $error("instruction acceptance wrong");

   a_rd_addr_index: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_addr_o == instr_i[4:0])
      else $error("read index does not follow the opcode");

endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the OR, copy and load-immediate executor.
// Assumes the bench plays the register file and drives rd_data_i itself.
`timescale 1ns/10ps
module testbench;
   logic                  clk_i         = 1'b0;
   logic                  rstn_i        = 1'b0;
   logic                  instr_valid_i = 1'b0;
   logic [11:0]           instr_i       = 12'h0000;
   logic [7:0]            rd_data_i     = 8'h00;
   logic [4:0]            rd_addr_o;
   oame_pkg::oame_wr_type wr_o;
   logic [7:0]            acc_o;
   logic                  zero_o;
   logic                  handled_o;
   int                    failures      = 0;
   int                    num_checks    = 0;
   int                    cycles        = 0;
   oame_exec dut (.clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .wr_o(wr_o), .acc_o(acc_o), .zero_o(zero_o),
      .handled_o(handled_o));
////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   // The tests need about 25 cycles, so 200 is a generous ceiling.
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 200)
      begin
         failures++;
         tally_and_finish();
      end
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   // Called at a falling edge, returns at the next one; valid stays high so that back-to-back
   // issues never drive it twice in one time step.
   task automatic issue(input logic [11:0] op, input logic [7:0] rd, input logic hit);
      instr_valid_i = 1'b1;
      instr_i = op;
      rd_data_i = rd;
      #1;
      chk("handled", {7'h00, hit}, {7'h00, handled_o});
      chk("rd_addr", {3'h0, op[4:0]}, {3'h0, rd_addr_o});
      @(negedge clk_i);
   endtask
   // One edge with nothing offered; the read data is inverted so a stale value never helps.
   task automatic idle(input logic [7:0] acc, input logic z);
      instr_valid_i = 1'b0;
      rd_data_i = ~rd_data_i;
      #1;
      chk("handled", 8'h00, {7'h00, handled_o});
      @(negedge clk_i);
      post(acc, z, 1'b0, 8'h00);
   endtask
   task automatic post(input logic [7:0] acc, input logic z, input logic en, input logic [7:0] wd);
      chk("acc", acc, acc_o);
      chk("zero", {7'h00, z}, {7'h00, zero_o});
      chk("wr_en", {7'h00, en}, {7'h00, wr_o.en});
      if (en)
      begin
         chk("wr_addr", {3'h0, instr_i[4:0]}, {3'h0, wr_o.addr});
         chk("wr_data", wd, wr_o.data);
      end
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic t_literal();
      issue(12'hc00, 8'ha5, 1'b1); post(8'h00, 1'b0, 1'b0, 8'h00);
      issue(12'hd00, 8'ha5, 1'b1); post(8'h00, 1'b1, 1'b0, 8'h00);
      issue(12'hc9a, 8'h00, 1'b1); post(8'h9a, 1'b1, 1'b0, 8'h00);
      issue(12'hd35, 8'h00, 1'b1); post(8'hbf, 1'b0, 1'b0, 8'h00);
      idle(8'hbf, 1'b0);
      $display("literal test done");
   endtask
   task automatic t_or_reg();
      issue(12'hc91, 8'h00, 1'b1); post(8'h91, 1'b0, 1'b0, 8'h00);
      issue(12'h113, 8'h13, 1'b1); post(8'h93, 1'b0, 1'b0, 8'h00);
      issue(12'h13f, 8'h40, 1'b1); post(8'h93, 1'b0, 1'b1, 8'hd3);
      issue(12'h153, 8'hff, 1'b0); post(8'h93, 1'b0, 1'b0, 8'h00);
      idle(8'h93, 1'b0);
      $display("register or test done");
   endtask
   task automatic t_copy();
      issue(12'h205, 8'h00, 1'b1); post(8'h00, 1'b1, 1'b0, 8'h00);
      issue(12'h23f, 8'h55, 1'b1); post(8'h00, 1'b0, 1'b1, 8'h55);
      issue(12'h233, 8'h00, 1'b1); post(8'h00, 1'b1, 1'b1, 8'h00);
      idle(8'h00, 1'b1);
      $display("copy test done");
   endtask
   // Mid-run reset from a state where the accumulator is non-zero and the zero flag is set.
   task automatic t_reset();
      issue(12'hc5a, 8'h00, 1'b1); post(8'h5a, 1'b1, 1'b0, 8'h00);
      instr_valid_i = 1'b0;
      rstn_i = 1'b0;
      #1;
      post(8'h00, 1'b0, 1'b0, 8'h00);
      @(negedge clk_i);
      rstn_i = 1'b1;
      issue(12'hd00, 8'h00, 1'b1); post(8'h00, 1'b1, 1'b0, 8'h00);
      idle(8'h00, 1'b1);
      $display("reset test done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(negedge clk_i);
      rstn_i = 1'b1;
      t_literal();
      t_or_reg();
      t_copy();
      t_reset();
      tally_and_finish();
   end
endmodule
